// [core/shared_clock_reset_logic.sv]
// clock enable generation, reset sequencing and apb status for the shared logic
//
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/1ps

// What this block does
// R01: master reset asserts the datapath and transceiver resets asynchronously, clears the control, latency and export registers
// R02: timer-done rises 500 ns after reset, core-timed
// R03: one combined transceiver reset-done, core-timed
// R04: datapath reset follows tx datapath rate
// R05: extra core-rate reset in newer variant only
// R06: transceiver tx reset timed to core rate
// R07: transceiver rx reset timed to core rate
// R08: user-ready follows pll lock, tx-two timed
// R09: core rate drives datapath only in older variant
// R10: newer variant: tx-two rate drives datapath, management
// R11: recovered rx clock exported, paces rx datapath
// R12: partner keeps management clock free-running, bounded
// R13: latency value latched on measure clock in newer variant when timestamping, readable
// R14: export init-done and clock-manager lock when timestamping
// R15: export tx pcs init reset when timestamping
// R16: resets assert at once, release through synchroniser
module shared_clock_reset_logic (
  input  wire logic                            clk,
  input  wire logic                            srst,
  // apb slave
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [clk_rst_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                     pwdata,
  output logic      [31:0]                     prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  // pins from the transceiver and the system
  input  wire logic                            masterReset,
  input  wire logic                            xcvrPllLockIn,
  input  wire logic                            xcvrTxResetDoneIn,
  input  wire logic                            xcvrRxResetDoneIn,
  input  wire logic                            rxRecoveredClockIn,
  input  wire logic                            latency_measure_clock,
  input  wire logic [clk_rst_pkg::LAT_W-1:0]   xcvrLatencyIn,
  input  wire logic                            txInitDoneIn,
  input  wire logic                            clkMgrLockedIn,
  input  wire logic                            tx_pcs_init_reset_in,
  // rate enables
  output logic                                 coreClkEn,
  output logic                                 tx_user_clock_two,
  output logic                                 txDatapathEn,
  output logic                                 mgmtEn,
  output logic                                 rxDatapathEn,
  // lock, ready and reset outputs
  output logic                                 xcvr_pll_locked_new,
  output logic                                 txUserReady,
  output logic                                 resetDone,
  output logic                                 resetTimerDone,
  output logic                                 datapathReset,
  output logic                                 coreReset,
  output logic                                 xcvrTxReset,
  output logic                                 xcvrRxReset,
  // timestamping exports
  output logic                                 txInitDone,
  output logic                                 clkMgrLocked,
  output logic                                 tx_pcs_init_reset
);

  // ---------------- pin synchronisers
  localparam int unsigned PIN_N = 8;
  logic [PIN_N-1:0] pinRaw;
  logic [PIN_N-1:0] pinMeta_q;
  logic [PIN_N-1:0] pinSync_q;

  assign pinRaw = {tx_pcs_init_reset_in, clkMgrLockedIn, txInitDoneIn, latency_measure_clock,
                   rxRecoveredClockIn, xcvrRxResetDoneIn, xcvrTxResetDoneIn, masterReset};

  // no reset here: these only mirror the pins
  always_ff @(posedge clk) begin
    pinMeta_q <= pinRaw;
    pinSync_q <= pinMeta_q;
  end

  logic mrSync;
  logic txDoneSync;
  logic rxDoneSync;
  logic rxRecSync;
  logic latClkSync;
  logic initDoneSync;
  logic mgrLockSync;
  logic pcsRstSync;

  assign mrSync       = pinSync_q[0];
  assign txDoneSync   = pinSync_q[1];
  assign rxDoneSync   = pinSync_q[2];
  assign rxRecSync    = pinSync_q[3];
  assign latClkSync   = pinSync_q[4];
  assign initDoneSync = pinSync_q[5];
  assign mgrLockSync  = pinSync_q[6];
  assign pcsRstSync   = pinSync_q[7];

  // pll lock has its own chain, paced later by the tx-two tick
  logic lockMeta_q;
  logic lockSync_q;

  always_ff @(posedge clk) begin
    lockMeta_q <= xcvrPllLockIn;
    lockSync_q <= lockMeta_q;
  end

  // ---------------- master reset
  logic ctrlNew_q;
  logic ctrlTs_q;
  logic softReset_q;
  logic mgmtReset;
  logic resetAssert;

  // raw pin asserts at once; release only follows the synchronised copy
  assign resetAssert = masterReset | mrSync | softReset_q;  // R01 R16
  assign mgmtReset   = srst | mrSync | softReset_q;  // R01

  // ---------------- rate dividers
  logic [clk_rst_pkg::DIV_W-1:0] coreDiv_q;
  logic [clk_rst_pkg::DIV_W-1:0] tx2Div_q;
  logic                          coreTick_q;
  logic                          tx2Tick_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      coreDiv_q  <= '0;
      coreTick_q <= 1'b0;
    end else if (coreDiv_q == clk_rst_pkg::CORE_DIV_LAST) begin
      coreDiv_q  <= '0;
      coreTick_q <= 1'b1;
    end else begin
      coreDiv_q  <= coreDiv_q + 1'b1;
      coreTick_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tx2Div_q  <= '0;
      tx2Tick_q <= 1'b0;
    end else if (tx2Div_q == clk_rst_pkg::TX2_DIV_LAST) begin
      tx2Div_q  <= '0;
      tx2Tick_q <= 1'b1;
    end else begin
      tx2Div_q  <= tx2Div_q + 1'b1;
      tx2Tick_q <= 1'b0;
    end
  end

  assign coreClkEn         = coreTick_q;
  assign tx_user_clock_two = tx2Tick_q;  // R10
  // older variant: core rate paces datapath and management
  assign txDatapathEn      = ctrlNew_q ? tx2Tick_q : coreTick_q;  // R09 R10
  assign mgmtEn            = ctrlNew_q ? tx2Tick_q : coreTick_q;  // R09 R10

  // ---------------- recovered rx clock, one pulse per rising edge
  logic rxRecPrev_q;
  logic rxTick_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      rxRecPrev_q <= 1'b0;
      rxTick_q    <= 1'b0;
    end else begin
      rxRecPrev_q <= rxRecSync;
      rxTick_q    <= rxRecSync & ~rxRecPrev_q;  // R11
    end
  end

  assign rxDatapathEn = rxTick_q;  // R11

  // ---------------- post-reset timer
  logic timerDone;

  reset_timer timer (
    .clk     (clk),
    .srst    (srst),
    .restart (mrSync | softReset_q),
    .tickEn  (coreTick_q),
    .done    (timerDone)
  );

  assign resetTimerDone = timerDone;  // R02

  // ---------------- reset channels
  rst_chan_if ch [clk_rst_pkg::NUM_RST] ();
  logic [clk_rst_pkg::NUM_RST-1:0] chReq;
  logic [clk_rst_pkg::NUM_RST-1:0] chTick;
  logic [clk_rst_pkg::NUM_RST-1:0] chOut;

  assign chReq[clk_rst_pkg::RST_DATAPATH]  = resetAssert;  // R04
  assign chTick[clk_rst_pkg::RST_DATAPATH] = txDatapathEn;  // R04
  assign chReq[clk_rst_pkg::RST_CORE]      = resetAssert;  // R05
  assign chTick[clk_rst_pkg::RST_CORE]     = coreTick_q;  // R05
  // transceiver resets also wait for the settling interval
  assign chReq[clk_rst_pkg::RST_XCVR_TX]   = resetAssert | ~timerDone;  // R06
  assign chTick[clk_rst_pkg::RST_XCVR_TX]  = coreTick_q;  // R06
  assign chReq[clk_rst_pkg::RST_XCVR_RX]   = resetAssert | ~timerDone;  // R07
  assign chTick[clk_rst_pkg::RST_XCVR_RX]  = coreTick_q;  // R07

  genvar gi;
  generate
    for (gi = 0; gi < clk_rst_pkg::NUM_RST; gi++) begin : g_rst
      assign ch[gi].assertReq = chReq[gi];
      assign ch[gi].tickEn    = chTick[gi];
      assign chOut[gi]        = ch[gi].rstOut;
      reset_release_sync sync (
        .clk  (clk),
        .srst (srst),
        .ch   (ch[gi])
      );  // R16
    end
  endgenerate

  assign datapathReset = chOut[clk_rst_pkg::RST_DATAPATH];  // R04
  // older variant has no separate core-rate reset
  assign coreReset     = ctrlNew_q & chOut[clk_rst_pkg::RST_CORE];  // R05
  assign xcvrTxReset   = chOut[clk_rst_pkg::RST_XCVR_TX];  // R06
  assign xcvrRxReset   = chOut[clk_rst_pkg::RST_XCVR_RX];  // R07

  // ---------------- combined reset-done and user-ready
  logic resetDone_q;
  logic userRdy_q;
  logic userRdyMid_q;

  always_ff @(posedge clk) begin
    if (mgmtReset) begin
      resetDone_q <= 1'b0;
    end else if (coreTick_q) begin
      resetDone_q <= txDoneSync & rxDoneSync;  // R03
    end
  end

  // two tx-two ticks of re-timing after the pin chain
  always_ff @(posedge clk) begin
    if (mgmtReset) begin
      userRdyMid_q <= 1'b0;
      userRdy_q    <= 1'b0;
    end else if (tx2Tick_q) begin
      userRdyMid_q <= lockSync_q;  // R08
      userRdy_q    <= userRdyMid_q;  // R08
    end
  end

  assign resetDone           = resetDone_q;  // R03
  assign txUserReady         = userRdy_q;  // R08
  assign xcvr_pll_locked_new = lockSync_q;

  // ---------------- timestamping exports
  logic [2:0] tsOut_q;

  always_ff @(posedge clk) begin
    if (mgmtReset) begin
      tsOut_q <= 3'h0;
    end else begin
      tsOut_q <= ctrlTs_q ? {pcsRstSync, mgrLockSync, initDoneSync} : 3'h0;  // R14 R15
    end
  end

  assign txInitDone        = tsOut_q[0];  // R14
  assign clkMgrLocked      = tsOut_q[1];  // R14
  assign tx_pcs_init_reset = tsOut_q[2];  // R15

  // ---------------- latency capture on measure clock edges
  logic                  latPrev_q;
  clk_rst_pkg::latency_t latency_q;

  // the value bus is assumed stable around the measure clock edge
  always_ff @(posedge clk) begin
    if (mgmtReset) begin
      latPrev_q <= 1'b0;
      latency_q <= clk_rst_pkg::LAT_RESET;
    end else begin
      latPrev_q <= latClkSync;
      if (ctrlNew_q && ctrlTs_q && latClkSync && !latPrev_q) begin
        latency_q <= xcvrLatencyIn;  // R13
      end
    end
  end

  // ---------------- apb slave
  logic        setup;
  logic        access;
  logic        hit;
  logic        wrCtrl;
  logic [31:0] rdData_d;
  logic [31:0] rdData_q;
  logic        err_q;
  logic [clk_rst_pkg::ST_W-1:0] status;

  assign setup  = psel & ~penable;
  assign access = psel & penable;
  assign hit    = (paddr == clk_rst_pkg::CTRL_OFF) || (paddr == clk_rst_pkg::STATUS_OFF)
                  || (paddr == clk_rst_pkg::LATENCY_OFF);
  assign wrCtrl = access & pwrite & (paddr == clk_rst_pkg::CTRL_OFF);

  always_comb begin
    status = '0;
    status[clk_rst_pkg::ST_PLL_LOCK_BIT] = lockSync_q;
    status[clk_rst_pkg::ST_TIMER_BIT]    = timerDone;
    status[clk_rst_pkg::ST_RSTDONE_BIT]  = resetDone_q;
    status[clk_rst_pkg::ST_USERRDY_BIT]  = userRdy_q;
    status[clk_rst_pkg::ST_DPRST_BIT]    = chOut[clk_rst_pkg::RST_DATAPATH];
    status[clk_rst_pkg::ST_CORERST_BIT]  = coreReset;
    status[clk_rst_pkg::ST_XTXRST_BIT]   = chOut[clk_rst_pkg::RST_XCVR_TX];
    status[clk_rst_pkg::ST_XRXRST_BIT]   = chOut[clk_rst_pkg::RST_XCVR_RX];
  end

  always_comb begin
    rdData_d = 32'h0000_0000;
    if (paddr == clk_rst_pkg::CTRL_OFF) begin
      rdData_d[clk_rst_pkg::CTRL_NEW_BIT] = ctrlNew_q;
      rdData_d[clk_rst_pkg::CTRL_TS_BIT]  = ctrlTs_q;
    end else if (paddr == clk_rst_pkg::STATUS_OFF) begin
      rdData_d[clk_rst_pkg::ST_W-1:0] = status;
    end else if (paddr == clk_rst_pkg::LATENCY_OFF) begin
      rdData_d[clk_rst_pkg::LAT_W-1:0] = latency_q;  // R13
    end
  end

  // read data and error are captured in the setup cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      rdData_q <= 32'h0000_0000;
      err_q    <= 1'b0;
    end else if (setup) begin
      rdData_q <= pwrite ? 32'h0000_0000 : rdData_d;
      err_q    <= ~hit | (pwrite & (paddr != clk_rst_pkg::CTRL_OFF));
    end
  end

  // control register; a master reset returns it to its defaults
  always_ff @(posedge clk) begin
    if (mgmtReset) begin
      ctrlNew_q <= clk_rst_pkg::CTRL_RESET[clk_rst_pkg::CTRL_NEW_BIT];  // R01
      ctrlTs_q  <= clk_rst_pkg::CTRL_RESET[clk_rst_pkg::CTRL_TS_BIT];  // R01
    end else if (wrCtrl) begin
      ctrlNew_q <= pwdata[clk_rst_pkg::CTRL_NEW_BIT];
      ctrlTs_q  <= pwdata[clk_rst_pkg::CTRL_TS_BIT];
    end
  end

  // soft reset is a one-cycle pulse, so it cannot lock itself in
  always_ff @(posedge clk) begin
    if (srst) begin
      softReset_q <= 1'b0;
    end else begin
      softReset_q <= wrCtrl & pwdata[clk_rst_pkg::CTRL_SOFTRST_BIT];
    end
  end

  assign pready  = 1'b1;
  assign prdata  = rdData_q;
  assign pslverr = access & err_q;

endmodule

// [core/clk_rst_pkg.sv]
// constants and types shared by the clock and reset sequencer
package clk_rst_pkg;

  // clock rate
  localparam int unsigned CLK_PERIOD_PS    = 8000;
  // reset timer, figure in ns and derived cycle count (least time, rounded up)
  localparam int unsigned TIMER_NS         = 500;
  localparam int unsigned TIMER_CYCLES     = (TIMER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned TIMER_W          = 7;
  localparam logic [TIMER_W-1:0] TIMER_LAST = TIMER_W'(TIMER_CYCLES - 1);

  // release synchroniser depth
  localparam int unsigned SYNC_STAGES      = 3;

  // enable dividers for the derived clock rates
  localparam int unsigned DIV_W            = 3;
  localparam logic [DIV_W-1:0] CORE_DIV_LAST = 3'h1;
  localparam logic [DIV_W-1:0] TX2_DIV_LAST  = 3'h3;

  // apb map
  localparam int unsigned ADDR_W           = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFF    = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFF  = 8'h04;
  localparam logic [ADDR_W-1:0] LATENCY_OFF = 8'h08;

  // control field positions and reset value
  localparam int unsigned CTRL_NEW_BIT     = 0;
  localparam int unsigned CTRL_TS_BIT      = 1;
  localparam int unsigned CTRL_SOFTRST_BIT = 2;
  localparam int unsigned CTRL_W           = 2;
  localparam logic [CTRL_W-1:0] CTRL_RESET  = 2'h0;

  // status field positions
  localparam int unsigned ST_PLL_LOCK_BIT  = 0;
  localparam int unsigned ST_TIMER_BIT     = 1;
  localparam int unsigned ST_RSTDONE_BIT   = 2;
  localparam int unsigned ST_USERRDY_BIT   = 3;
  localparam int unsigned ST_DPRST_BIT     = 4;
  localparam int unsigned ST_CORERST_BIT   = 5;
  localparam int unsigned ST_XTXRST_BIT    = 6;
  localparam int unsigned ST_XRXRST_BIT    = 7;
  localparam int unsigned ST_W             = 8;

  // latency capture
  localparam int unsigned LAT_W            = 16;
  localparam logic [LAT_W-1:0] LAT_RESET    = 16'h0000;

  // synchronised reset channels
  localparam int unsigned NUM_RST          = 4;
  localparam int unsigned RST_DATAPATH     = 0;
  localparam int unsigned RST_CORE         = 1;
  localparam int unsigned RST_XCVR_TX      = 2;
  localparam int unsigned RST_XCVR_RX      = 3;

  typedef logic [LAT_W-1:0] latency_t;

endpackage

// [core/rst_chan_if.sv]
// carrier between the sequencer and one reset release synchroniser
`timescale 1ns/1ps
interface rst_chan_if;
  logic assertReq;
  logic tickEn;
  logic rstOut;

  modport src  (output assertReq, output tickEn, input rstOut);
  modport sink (input assertReq, input tickEn, output rstOut);
endinterface

// [core/reset_release_sync.sv]
// reset output: immediate assertion, release through a tick-paced flop chain
`timescale 1ns/1ps
module reset_release_sync (
  input  wire logic   clk,
  input  wire logic   srst,
  rst_chan_if.sink    ch
);
  logic [clk_rst_pkg::SYNC_STAGES-1:0] stages_q;

  always_ff @(posedge clk) begin
    if (srst || ch.assertReq) begin
      stages_q <= '1;
    end else if (ch.tickEn) begin
      stages_q <= {stages_q[clk_rst_pkg::SYNC_STAGES-2:0], 1'b0};
    end
  end

  // assertion bypasses the chain, release waits for the last stage
  assign ch.rstOut = ch.assertReq | stages_q[clk_rst_pkg::SYNC_STAGES-1];
endmodule

// [core/reset_timer.sv]
// post-reset interval timer, done flag advanced on the core rate tick
`timescale 1ns/1ps
module reset_timer (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic restart,
  input  wire logic tickEn,
  output logic      done
);
  logic [clk_rst_pkg::TIMER_W-1:0] count_q;
  logic                            elapsed_q;
  logic                            done_q;

  always_ff @(posedge clk) begin
    if (srst || restart) begin
      count_q   <= '0;
      elapsed_q <= 1'b0;
    end else if (!elapsed_q) begin
      if (count_q == clk_rst_pkg::TIMER_LAST) begin
        elapsed_q <= 1'b1;
      end else begin
        count_q <= count_q + 1'b1;
      end
    end
  end

  // done only rises on a core tick so it lines up with the core rate
  always_ff @(posedge clk) begin
    if (srst || restart) begin
      done_q <= 1'b0;
    end else if (tickEn) begin
      done_q <= elapsed_q;
    end
  end

  assign done = done_q;
endmodule

// [testbench/xcvr_model.sv]
// transceiver-side model driving the sequencer's input pins
`timescale 1ns/1ps
module xcvr_model (
  input  wire logic                  clk,
  input  wire logic                  lockOn,
  input  wire logic                  doneOn,
  input  wire logic                  latGo,
  input  wire clk_rst_pkg::latency_t latVal,
  input  wire logic [2:0]            tsVal,
  output logic                       pllLock,
  output logic                       txDone,
  output logic                       rxDone,
  output logic                       recClk,
  output logic                       latClk,
  output clk_rst_pkg::latency_t      latency,
  output logic [2:0]                 tsPins
);
  logic [2:0] recDiv;
  initial begin
    {pllLock, txDone, rxDone, recClk, latClk, recDiv, tsPins} = '0;
    latency = 16'hFFFF;
  end
  // recovered clock runs free, unrelated to the tx rates
  always @(posedge clk) begin
    pllLock <= lockOn;
    txDone <= doneOn;
    rxDone <= doneOn;
    tsPins <= tsVal;
    recDiv <= (recDiv == 3'h4) ? 3'h0 : recDiv + 3'h1;
    if (recDiv == 3'h4) recClk <= !recClk;
  end
  // value steady well around the measuring edge, scrambled outside it
  always @(posedge clk) begin
    if (latGo) begin
      latency <= latVal;
      repeat (4) @(posedge clk);
      latClk <= 1'b1;
      repeat (4) @(posedge clk);
      latClk <= 1'b0;
      latency <= ~latVal;
    end
  end
endmodule

// [testbench/shared_clock_reset_logic_props.sv]
// assertion checker for the shared clock and reset sequencer
`timescale 1ns/1ps
module shared_clock_reset_logic_chk (
  input wire logic                           clk,
  input wire logic                           srst,
  input wire logic                           psel,
  input wire logic                           penable,
  input wire logic                           pwrite,
  input wire logic [clk_rst_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0]                    pwdata,
  input wire logic                           masterReset,
  input wire logic                           xcvrPllLockIn,
  input wire logic                           rxRecoveredClockIn,
  input wire logic                           coreClkEn,
  input wire logic                           tx_user_clock_two,
  input wire logic                           txDatapathEn,
  input wire logic                           rxDatapathEn,
  input wire logic                           xcvr_pll_locked_new,
  input wire logic                           txUserReady,
  input wire logic                           resetDone,
  input wire logic                           resetTimerDone,
  input wire logic                           datapathReset,
  input wire logic                           xcvrTxReset,
  input wire logic                           xcvrRxReset
);
  logic [7:0] sinceCnt_q;
  // restarts at the earliest cause, so the design's own count is never ahead
  always_ff @(posedge clk) begin
    if (srst || masterReset || (psel && penable && pwrite
        && paddr == clk_rst_pkg::CTRL_OFF && pwdata[clk_rst_pkg::CTRL_SOFTRST_BIT]))
      sinceCnt_q <= 8'h00;
    else if (sinceCnt_q != 8'hFF)
      sinceCnt_q <= sinceCnt_q + 8'h01;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence coreTick;
    coreClkEn ##1 !coreClkEn ##1 coreClkEn;
  endsequence
  sequence txTwoTick;
    tx_user_clock_two ##1 !tx_user_clock_two [*3] ##1 tx_user_clock_two;
  endsequence
  sequence xcvrRelease;
    ##[1:24] (!xcvrTxReset && !xcvrRxReset);
  endsequence
  AST_CORE_RATE: assert property (coreClkEn |-> coreTick)
    else $error("core rate enable not every second cycle");
  AST_TX2_RATE: assert property (tx_user_clock_two |-> txTwoTick)
    else $error("tx two enable not every fourth cycle");
  AST_MR_ASSERT: assert property (masterReset |-> datapathReset & xcvrTxReset & xcvrRxReset)
    else $error("reset outputs not high with master reset");
  AST_TIMER_EARLY: assert property ($rose(resetTimerDone) |->
    $past(coreClkEn) && sinceCnt_q >= 8'h3F)
    else $error("timer done too early or off the core tick");
  AST_TIMER_LATE: assert property (sinceCnt_q == 8'h5A |-> resetTimerDone)
    else $error("timer done missing");
  AST_XCVR_WAIT: assert property ($rose(resetTimerDone) |-> xcvrTxReset && xcvrRxReset)
    else $error("transceiver resets released before timer done");
  AST_XCVR_FREE: assert property (disable iff (srst || masterReset)
    $rose(resetTimerDone) |-> xcvrRelease)
    else $error("transceiver resets not released");
  AST_DP_PACE: assert property ($fell(datapathReset) |-> $past(txDatapathEn))
    else $error("datapath reset released off the tx pace");
  AST_READY_PACE: assert property ($rose(txUserReady) |->
    $past(tx_user_clock_two) && xcvr_pll_locked_new)
    else $error("user ready rose without lock or off tick");
  AST_LOCK_SYNC: assert property ($rose(xcvrPllLockIn) |-> ##[1:3] xcvr_pll_locked_new)
    else $error("lock not passed on");
  AST_DONE_PACE: assert property ($rose(resetDone) |-> $past(coreClkEn))
    else $error("reset done rose off the core tick");
  AST_RX_PACE: assert property ($rose(rxRecoveredClockIn) |-> ##[2:5] rxDatapathEn)
    else $error("rx pulse missing");
endmodule
bind shared_clock_reset_logic shared_clock_reset_logic_chk i_chk (.clk(clk), .srst(srst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .masterReset(masterReset), .xcvrPllLockIn(xcvrPllLockIn),
  .rxRecoveredClockIn(rxRecoveredClockIn), .coreClkEn(coreClkEn),
  .tx_user_clock_two(tx_user_clock_two), .txDatapathEn(txDatapathEn),
  .rxDatapathEn(rxDatapathEn), .xcvr_pll_locked_new(xcvr_pll_locked_new),
  .txUserReady(txUserReady), .resetDone(resetDone), .resetTimerDone(resetTimerDone),
  .datapathReset(datapathReset), .xcvrTxReset(xcvrTxReset), .xcvrRxReset(xcvrRxReset));

// [testbench/tb.sv]
// self-checking bench for the shared clock and reset sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin samplesChecked++; if ((a) !== (b)) begin errCount++; \
  $display("BAD %0t got %h exp %h", $time, (a), (b)); end end
module tb;
  typedef struct {logic rd; logic err; logic [31:0] msk; logic [31:0] dat;} note_t;
  localparam logic [7:0] CTRL_A = clk_rst_pkg::CTRL_OFF;
  localparam logic [7:0] STAT_A = clk_rst_pkg::STATUS_OFF;
  localparam logic [7:0] LAT_A  = clk_rst_pkg::LATENCY_OFF;
  logic                  clk, srst, psel, penable, pwrite, masterReset, pready, pslverr;
  logic [7:0]            paddr;
  logic [31:0]           pwdata, prdata, seed, r;
  logic                  lockOn, doneOn, latGo, pllLock, txDone, rxDone, recClk, recPrev, latClk;
  clk_rst_pkg::latency_t latVal, latency;
  logic [2:0]            tsVal, tsPins;
  logic                  coreClkEn, txTwo, txDatapathEn, mgmtEn, rxDatapathEn, lockOut;
  logic                  txUserReady, resetDone, resetTimerDone, datapathReset, coreReset;
  logic                  xcvrTxReset, xcvrRxReset, txInitDone, clkMgrLocked, pcsRst;
  int                    errCount, samplesChecked, cycles, edges, pulses;
  note_t                 expQ[$];
  note_t                 n;

  shared_clock_reset_logic i_dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .masterReset(masterReset), .xcvrPllLockIn(pllLock),
    .xcvrTxResetDoneIn(txDone), .xcvrRxResetDoneIn(rxDone), .rxRecoveredClockIn(recClk),
    .latency_measure_clock(latClk), .xcvrLatencyIn(latency), .txInitDoneIn(tsPins[2]),
    .clkMgrLockedIn(tsPins[1]), .tx_pcs_init_reset_in(tsPins[0]), .coreClkEn(coreClkEn),
    .tx_user_clock_two(txTwo), .txDatapathEn(txDatapathEn), .mgmtEn(mgmtEn),
    .rxDatapathEn(rxDatapathEn), .xcvr_pll_locked_new(lockOut), .txUserReady(txUserReady),
    .resetDone(resetDone), .resetTimerDone(resetTimerDone), .datapathReset(datapathReset),
    .coreReset(coreReset), .xcvrTxReset(xcvrTxReset), .xcvrRxReset(xcvrRxReset),
    .txInitDone(txInitDone), .clkMgrLocked(clkMgrLocked), .tx_pcs_init_reset(pcsRst));
  xcvr_model i_xcvr (.clk(clk), .lockOn(lockOn), .doneOn(doneOn), .latGo(latGo),
    .latVal(latVal), .tsVal(tsVal), .pllLock(pllLock), .txDone(txDone), .rxDone(rxDone),
    .recClk(recClk), .latClk(latClk), .latency(latency), .tsPins(tsPins));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic end_sim();
    if (errCount == 0 && samplesChecked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // one idle cycle after each transfer keeps the strobes single-driven per step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     input logic [31:0] msk, input logic [31:0] ed, input logic ee);
    expQ.push_back('{!w, ee, msk, ed});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  always @(posedge clk) begin
    cycles++;
    recPrev <= recClk;
    if (rxDatapathEn === 1'b1) pulses++;
    if (recClk && !recPrev) edges++;
    if (cycles == 20000) begin
      errCount++;
      end_sim();
    end
    if (psel && penable && pready) begin
      if (expQ.size() == 0) begin
        errCount++;
        $display("BAD %0t transfer without a note", $time);
      end else begin
        n = expQ.pop_front();
        `CHK(pslverr, n.err)
        if (n.rd) `CHK(prdata & n.msk, n.dat)
      end
    end
  end

  initial begin
    seed = 32'h784E;
    {srst, lockOn, doneOn} = 3'h7;
    {psel, penable, pwrite, masterReset, latGo, recPrev} = 6'h00;
    {paddr, pwdata, latVal, tsVal} = '0;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    apb(0, CTRL_A, 0, 32'hFFFFFFFF, 0, 0);
    apb(0, LAT_A, 0, 32'hFFFFFFFF, 0, 0);
    apb(1, STAT_A, 32'hFFFFFFFF, 0, 0, 1);
    apb(1, LAT_A, 32'h0000FFFF, 0, 0, 1);
    apb(0, 8'h0C, 0, 32'hFFFFFFFF, 0, 1);
    repeat (100) @(posedge clk);
    apb(0, STAT_A, 0, 32'hFFFFFFFF, 32'h0000000F, 0);
    @(negedge clk);
    repeat (8) begin @(negedge clk); `CHK({txDatapathEn, mgmtEn}, {2{coreClkEn}}) end
    @(posedge clk);
    r = $random(seed);
    apb(1, CTRL_A, {r[31:3], 3'h3}, 0, 0, 0);
    apb(0, CTRL_A, 0, 32'hFFFFFFFF, 32'h00000003, 0);
    repeat (8) begin @(negedge clk); `CHK({txDatapathEn, mgmtEn}, {2{txTwo}}) end
    @(posedge clk);
    r = $random(seed);
    tsVal <= r[2:0];
    latVal <= r[31:16];
    latGo <= 1'b1;
    @(posedge clk);
    latGo <= 1'b0;
    repeat (20) @(posedge clk);
    apb(0, LAT_A, 0, 32'hFFFFFFFF, {16'h0000, latVal}, 0);
    @(negedge clk);
    `CHK({txInitDone, clkMgrLocked, pcsRst}, tsVal)
    @(posedge clk);
    masterReset <= 1'b1;
    tsVal <= 3'h7;
    @(negedge clk);
    `CHK({datapathReset, xcvrTxReset, xcvrRxReset, coreReset}, 4'hF)
    repeat (5) @(posedge clk);
    masterReset <= 1'b0;
    @(posedge clk);
    apb(0, CTRL_A, 0, 32'hFFFFFFFF, 0, 0);
    apb(0, STAT_A, 0, 32'h00000002, 0, 0);
    @(negedge clk);
    `CHK({txInitDone, clkMgrLocked, pcsRst}, 3'h0)
    repeat (100) @(posedge clk);
    apb(0, STAT_A, 0, 32'hFFFFFFFF, 32'h0000000F, 0);
    lockOn <= 1'b0;
    repeat (20) @(posedge clk);
    apb(0, STAT_A, 0, 32'h00000009, 0, 0);
    lockOn <= 1'b1;
    repeat (20) @(posedge clk);
    apb(0, STAT_A, 0, 32'h00000009, 32'h00000009, 0);
    apb(1, CTRL_A, 32'h00000004, 0, 0, 0);
    repeat (4) @(posedge clk);
    apb(0, STAT_A, 0, 32'h00000002, 0, 0);
    apb(0, CTRL_A, 0, 32'hFFFFFFFF, 0, 0);
    edges = 0;
    pulses = 0;
    repeat (200) @(posedge clk);
    `CHK(pulses >= edges - 1 && pulses <= edges + 1, 1'b1)
    end_sim();
  end
endmodule
